// ### pkg/csu_defines.svh
`ifndef CSU_DEFINES_SVH
`define CSU_DEFINES_SVH
// register byte offsets
`define CSU_CTRL_OFS 12'h000
`define CSU_STAT_OFS 12'h004
`define CSU_FTW_OFS 12'h008
`define CSU_PLL_OFS 12'h00C
`define CSU_BUSDIV_OFS 12'h010
`define CSU_CPUDIV_OFS 12'h014
`define CSU_DDIV_OFS 12'h040
`define CSU_ADIV_OFS 12'h080
// ctrl fields
`define CSU_CTRL_TW_CLR 0
`define CSU_CTRL_FTW_IE 1
`define CSU_CTRL_STW_IE 2
`define CSU_CTRL_PLL_EN 3
`define CSU_CTRL_IMO_USB 4
`define CSU_CTRL_IMO_LSB 8
`define CSU_CTRL_DBL_LSB 12
`define CSU_CTRL_RESET 32'h0000_0000
// timing: ilo tick rates as master cycles, pll lock time
`define CSU_CLK_HZ 10000000
`define CSU_1KHZ_HZ 1000
`define CSU_100KHZ_HZ 100000
`define CSU_PLL_LOCK_US 250
`define CSU_PLL_LOCK_CYC ((`CSU_PLL_LOCK_US * (`CSU_CLK_HZ / 1000000)))
`define CSU_DIV100K_CYC (`CSU_CLK_HZ / `CSU_100KHZ_HZ)
`define CSU_1K_PER_100K (`CSU_100KHZ_HZ / `CSU_1KHZ_HZ)
`define CSU_DIV_RESET 16'h0002
`endif

// ### pkg/csu_pkg.sv
package csu_pkg;
    // divider configuration: source select and divide value
    typedef struct packed {
        logic [2:0] src;
        logic [15:0] div;
    } csu_div_cfg_t;
    typedef enum logic [1:0] {
        csu_ref_imo,
        csu_ref_xtal,
        csu_ref_fabric,
        csu_ref_rsvd
    } csu_ref_t;
    typedef enum {
        csu_pll_off,
        csu_pll_wait,
        csu_pll_locked
    } csu_pll_st_t;
endpackage : csu_pkg

// ### rtl/csu_top.sv
`timescale 1ns/100ps
`include "csu_defines.svh"
module csu_top #(
    parameter int NDIG = 8,
    parameter int NANA = 4,
    parameter int PLL_LOCK_CYC = `CSU_PLL_LOCK_CYC,
    parameter int WATCH_HZ = 32768
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // clock-source enables, synchronous to hclk, one pulse per edge
    input wire logic [7:0] src_en,
    input wire logic [7:0] fabric_clk_en,
    input wire logic watch_tick,
    input wire logic hibernate,
    input wire logic debug_halt,
    output logic [NDIG-1:0] dig_clk,
    output logic [NANA-1:0] ana_clk,
    output logic bus_clk,
    output logic cpu_clk,
    output logic tick_1khz_clock,
    output logic low_power_100khz_clock,
    output logic reduced_33khz_clock,
    output logic [12:0] slow_tick_counter,
    output logic [4:0] fast_tick,
    output logic stw_irq,
    output logic ftw_irq,
    output logic rtc_irq,
    output logic pll_lock,
    output logic [2:0] imo_freq_sel,
    output logic imo_usb_mode,
    output logic [1:0] pll_ref_sel,
    output logic [1:0] dbl_ref_sel,
    output logic [11:0] pll_ratio
);
    localparam int NDIV = NDIG + NANA;
    localparam int C100K = `CSU_DIV100K_CYC;
    localparam int C1K = `CSU_1K_PER_100K;

    logic [31:0] ctrl_q;
    logic [4:0] ftw_tc_q;
    logic [11:0] pll_ratio_q;
    logic [15:0] bus_div_q;
    logic [3:0] cpu_div_q;
    csu_pkg::csu_div_cfg_t cfg_q [NDIV];
    logic ap_q;
    logic ap_wr_q;
    logic [11:0] ap_addr_q;
    csu_pkg::csu_pll_st_t pll_st_q;
    logic [$clog2(PLL_LOCK_CYC+1)-1:0] pll_cnt_q;

    // ahb address phase capture; always zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            ap_wr_q <= 1'b0;
            ap_addr_q <= 12'h000;
        end else if (hready) begin
            ap_q <= hsel && htrans[1];
            ap_wr_q <= hwrite;
            ap_addr_q <= haddr;
        end
    end

    // register writes in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `CSU_CTRL_RESET;
            ftw_tc_q <= 5'h1F;
            pll_ratio_q <= 12'h001;
            bus_div_q <= `CSU_DIV_RESET;
            cpu_div_q <= 4'h1;
            for (int i = 0; i < NDIV; i++) begin
                cfg_q[i] <= '{src: 3'h0, div: `CSU_DIV_RESET};
            end
        end else begin
            ctrl_q[`CSU_CTRL_TW_CLR] <= 1'b0;
            if (ap_q && ap_wr_q) begin
                if (ap_addr_q == `CSU_CTRL_OFS) ctrl_q <= hwdata;
                if (ap_addr_q == `CSU_FTW_OFS) ftw_tc_q <= hwdata[4:0];
                if (ap_addr_q == `CSU_PLL_OFS) pll_ratio_q <= hwdata[11:0];
                if (ap_addr_q == `CSU_BUSDIV_OFS) bus_div_q <= hwdata[15:0];
                if (ap_addr_q == `CSU_CPUDIV_OFS) cpu_div_q <= hwdata[3:0];
                for (int i = 0; i < NDIV; i++) begin
                    if (ap_addr_q == 12'(`CSU_DDIV_OFS + 4 * i)) begin
                        cfg_q[i] <= '{src: hwdata[18:16], div: hwdata[15:0]};
                    end
                end
            end
        end
    end

    // read mux; unmapped reads give zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (ap_addr_q == `CSU_CTRL_OFS) hrdata = ctrl_q;
        if (ap_addr_q == `CSU_STAT_OFS) hrdata = {18'h0, pll_lock, slow_tick_counter};
        if (ap_addr_q == `CSU_FTW_OFS) hrdata = {22'h0, fast_tick, ftw_tc_q};
        if (ap_addr_q == `CSU_PLL_OFS) hrdata = {20'h0, pll_ratio_q};
        if (ap_addr_q == `CSU_BUSDIV_OFS) hrdata = {16'h0, bus_div_q};
        if (ap_addr_q == `CSU_CPUDIV_OFS) hrdata = {28'h0, cpu_div_q};
        for (int i = 0; i < NDIV; i++) begin
            if (ap_addr_q == 12'(`CSU_DDIV_OFS + 4 * i)) hrdata = {13'h0, cfg_q[i]};
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // main osc trims and modes; reference selects
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imo_freq_sel <= 3'h0;
            imo_usb_mode <= 1'b0;
            pll_ref_sel <= 2'h0;
            dbl_ref_sel <= 2'h0;
            pll_ratio <= 12'h001;
        end else begin
            imo_freq_sel <= ctrl_q[`CSU_CTRL_IMO_LSB +: 3];
            imo_usb_mode <= ctrl_q[`CSU_CTRL_IMO_USB];
            pll_ref_sel <= ctrl_q[`CSU_CTRL_IMO_LSB + 4 +: 2];
            dbl_ref_sel <= ctrl_q[`CSU_CTRL_DBL_LSB +: 2];
            pll_ratio <= pll_ratio_q;
        end
    end

    // pll lock timer; lock drops when disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_st_q <= csu_pkg::csu_pll_off;
            pll_cnt_q <= '0;
            pll_lock <= 1'b0;
        end else if (!ctrl_q[`CSU_CTRL_PLL_EN]) begin
            pll_st_q <= csu_pkg::csu_pll_off;
            pll_cnt_q <= '0;
            pll_lock <= 1'b0;
        end else begin
            unique case (pll_st_q)
                csu_pkg::csu_pll_off: pll_st_q <= csu_pkg::csu_pll_wait;
                csu_pkg::csu_pll_wait: begin
                    pll_cnt_q <= pll_cnt_q + 1'b1;
                    if (pll_cnt_q == $bits(pll_cnt_q)'(PLL_LOCK_CYC - 2)) begin
                        pll_st_q <= csu_pkg::csu_pll_locked;
                        pll_lock <= 1'b1;
                    end
                end
                csu_pkg::csu_pll_locked: pll_lock <= 1'b1;
            endcase
        end
    end

    logic [$clog2(C100K)-1:0] pre_q;
    logic [$clog2(C1K)-1:0] k1_q;
    logic [1:0] k33_q;
    logic en100k;
    logic en1k;
    assign en100k = (pre_q == $bits(pre_q)'(C100K - 1));
    assign en1k = en100k && (k1_q == $bits(k1_q)'(C1K - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= '0;
            k1_q <= '0;
            k33_q <= 2'h0;
            tick_1khz_clock <= 1'b0;
            low_power_100khz_clock <= 1'b0;
            reduced_33khz_clock <= 1'b0;
        end else begin
            pre_q <= en100k ? '0 : pre_q + 1'b1;
            if (en100k) k1_q <= en1k ? '0 : k1_q + 1'b1;
            low_power_100khz_clock <= en100k;
            tick_1khz_clock <= en1k;
            if (en100k) k33_q <= (k33_q == 2'h2) ? 2'h0 : k33_q + 2'h1;
            reduced_33khz_clock <= en100k && (k33_q == 2'h2);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_tick_counter <= 13'h0000;
            stw_irq <= 1'b0;
        end else begin
            stw_irq <= 1'b0;
            // firmware clear wins over the tick
            if (ctrl_q[`CSU_CTRL_TW_CLR]) begin
                slow_tick_counter <= 13'h0000;
            end else if (en1k && !hibernate && !debug_halt) begin
                slow_tick_counter <= slow_tick_counter + 13'h0001;
                // periodic interrupt and wakeup on wrap
                stw_irq <= ctrl_q[`CSU_CTRL_STW_IE] && (slow_tick_counter == 13'h1FFF);
            end
        end
    end

    // fast tick counter with terminal count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_tick <= 5'h00;
            ftw_irq <= 1'b0;
        end else begin
            ftw_irq <= 1'b0;
            if (en100k && !hibernate) begin
                fast_tick <= (fast_tick >= ftw_tc_q) ? 5'h00 : fast_tick + 5'h01;
                ftw_irq <= ctrl_q[`CSU_CTRL_FTW_IE] && (fast_tick >= ftw_tc_q);
            end
        end
    end

    // one-second pulse counted from watch crystal ticks
    logic [15:0] rtc_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rtc_q <= 16'h0000;
            rtc_irq <= 1'b0;
        end else begin
            rtc_irq <= 1'b0;
            if (watch_tick) begin
                rtc_q <= (rtc_q == 16'(WATCH_HZ - 1)) ? 16'h0000 : rtc_q + 16'h0001;
                rtc_irq <= (rtc_q == 16'(WATCH_HZ - 1));
            end
        end
    end

    // dividers: toggle output at half count gives 50 percent
    // duty at even divide values; new config is taken only at the end of a period so no runt
    logic [NDIV-1:0] div_out;
    genvar g;
    generate
        for (g = 0; g < NDIV; g++) begin : g_div
            logic [15:0] cnt_q;
            csu_pkg::csu_div_cfg_t act_q;
            logic out_q;
            logic en;
            logic [15:0] lim;
            // digital dividers may pick extra fabric clocks in src 7
            assign en = (g < NDIG && act_q.src == 3'h7) ? fabric_clk_en[g % 8]
                                                           : src_en[act_q.src];
            assign lim = (act_q.div < 16'h0002) ? 16'h0002 : act_q.div;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q <= 16'h0000;
                    act_q <= '{src: 3'h0, div: `CSU_DIV_RESET};
                    out_q <= 1'b0;
                end else if (en) begin
                    if (cnt_q == lim - 16'h0001) begin
                        cnt_q <= 16'h0000;
                        out_q <= 1'b0;
                        act_q <= cfg_q[g];
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                        if (cnt_q == (lim >> 1) - 16'h0001) out_q <= 1'b1;
                    end
                end
            end
            assign div_out[g] = out_q;
        end
    endgenerate

    // bus divider on master clock, cpu divider on bus clock edges
    logic [15:0] bcnt_q;
    logic [3:0] ccnt_q;
    logic bus_en;
    assign bus_en = (bcnt_q >= bus_div_q - 16'h0001);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bcnt_q <= 16'h0000;
            ccnt_q <= 4'h0;
            bus_clk <= 1'b0;
            cpu_clk <= 1'b0;
            dig_clk <= '0;
            ana_clk <= '0;
        end else begin
            bcnt_q <= bus_en ? 16'h0000 : bcnt_q + 16'h0001;
            bus_clk <= bus_en;
            if (bus_en) ccnt_q <= (ccnt_q >= cpu_div_q - 4'h1) ? 4'h0 : ccnt_q + 4'h1;
            cpu_clk <= bus_en && (ccnt_q >= cpu_div_q - 4'h1);
            // resynchronise divider outputs to master clock
            dig_clk <= div_out[NDIG-1:0];
            ana_clk <= div_out[NDIV-1:NDIG];
        end
    end

    // doubler and pll-before-sleep are analog/software matters
    // fast counter clears on the tick after it reaches or passes terminal count
    a_ftw_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(en100k) && !$past(hibernate) && $past(fast_tick) >= $past(ftw_tc_q)
        |-> fast_tick == 5'h00) else $error("fast tick failed to autoreset");
    // slow counter steps by one on a tick
    a_stw_step: assert property (@(posedge hclk) disable iff (!hresetn)
        en1k && !hibernate && !debug_halt && !ctrl_q[0]
        |=> slow_tick_counter == $past(slow_tick_counter) + 13'h0001)
        else $error("slow tick did not step");
    a_stw_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (hibernate || debug_halt) && !ctrl_q[0] |=> $stable(slow_tick_counter))
        else $error("slow tick moved while stopped");
    a_stw_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q[0] |=> slow_tick_counter == 13'h0000) else $error("clear ignored");
    // 33 kHz pulses fall only on cycles that also carry a 100 kHz pulse
    a_k33_div: assert property (@(posedge hclk) disable iff (!hresetn)
        reduced_33khz_clock |-> low_power_100khz_clock) else $error("33k off grid");
    // lock rises only with the enable set three cycles before
    a_pll_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pll_lock) |-> $past(ctrl_q[3], 3)) else $error("early lock");
    a_ftw_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        ftw_irq |-> $past(ctrl_q[1]) && fast_tick == 5'h00) else $error("bad ftw irq");
    a_stw_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        stw_irq |-> slow_tick_counter == 13'h0000) else $error("bad stw irq");
endmodule : csu_top

// ### test/csu_src_model.sv
`timescale 1ns/100ps
// stand-in for the oscillators and fabric feeding the unit: fixed-spacing enable trains
module csu_src_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic watch_run,
    output logic [7:0] src_en,
    output logic [7:0] fabric_clk_en,
    output logic watch_tick
);
    logic [7:0] phase_q;
    // free-running phase; a reset source gives no edges at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 8'h00;
        end else begin
            phase_q <= phase_q + 8'h01;
        end
    end
    // source i pulses every 1, 2 or 4 cycles; spacings differ so a wrong mux pick shows
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            src_en[i] = hresetn && ((phase_q & ((8'h01 << (i % 3)) - 8'h01)) == 8'h00);
        end
    end
    // fabric clocks every 4 cycles, watch crystal every 8 cycles only while running
    assign fabric_clk_en = {8{hresetn && (phase_q[1:0] == 2'h0)}};
    assign watch_tick = hresetn && watch_run && (phase_q[2:0] == 3'h0);
endmodule : csu_src_model

// ### test/tb.sv
`timescale 1ns/100ps
`include "csu_defines.svh"
module tb;
    localparam int T100K = `CSU_DIV100K_CYC;
    localparam int T1K = T100K * `CSU_1K_PER_100K;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
    logic hibernate = 1'b0, debug_halt = 1'b0, watch_run = 1'b0;
    logic hreadyout, hresp, bus_clk, cpu_clk, tick_1khz_clock, low_power_100khz_clock;
    logic reduced_33khz_clock, stw_irq, ftw_irq, rtc_irq, pll_lock, imo_usb_mode, watch_tick;
    logic [7:0] src_en, fabric_clk_en, dig_clk;
    logic [3:0] ana_clk;
    logic [12:0] slow_tick_counter, c0;
    logic [4:0] fast_tick;
    logic [2:0] imo_freq_sel;
    logic [1:0] pll_ref_sel, dbl_ref_sel;
    logic [11:0] pll_ratio;
    int failures = 0, num_checks = 0, len, hi, n;
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // 10 MHz master clock
    always #50 hclk = ~hclk;
    csu_top #(.PLL_LOCK_CYC(10), .WATCH_HZ(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .src_en,
        .fabric_clk_en, .watch_tick, .hibernate, .debug_halt, .dig_clk, .ana_clk, .bus_clk,
        .cpu_clk, .tick_1khz_clock, .low_power_100khz_clock, .reduced_33khz_clock,
        .slow_tick_counter, .fast_tick, .stw_irq, .ftw_irq, .rtc_irq, .pll_lock, .imo_freq_sel,
        .imo_usb_mode, .pll_ref_sel, .dbl_ref_sel, .pll_ratio);
    csu_src_model src (.hclk, .hresetn, .watch_run, .src_en, .fabric_clk_en, .watch_tick);
    // selector so one timing task can watch any of eleven generated clocks and pulses
    function automatic logic pick(input int k);
        logic [10:0] v;
        v = {cpu_clk, bus_clk, dig_clk[7], ana_clk[0], dig_clk[1], dig_clk[0], rtc_irq,
             ftw_irq, tick_1khz_clock, reduced_33khz_clock, low_power_100khz_clock};
        return v[k];
    endfunction : pick
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // one single-word transfer; the address phase is held until ready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
        rd = hrdata;
        if (k >= 100) begin
            failures++;
            $display("MISMATCH t=%0t bus transfer timed out", $time);
            print_verdict();
        end
    endtask : xfer
    // edge count between two rising edges of the watched signal, and its high time
    task automatic gap(input int k, input int lim);
        logic p;
        int r;
        p = 1'b1;
        r = 0;
        len = 0;
        hi = 0;
        n = 0;
        while (r < 2 && n < lim) begin
            @(posedge hclk);
            if (r == 1) len++;
            if (r == 1 && pick(k) === 1'b1) hi++;
            if (pick(k) === 1'b1 && p !== 1'b1) r++;
            p = pick(k);
            n++;
        end
        if (r < 2) begin
            failures++;
            $display("MISMATCH t=%0t no second rising edge on watched signal %0d", $time, k);
            print_verdict();
        end
    endtask : gap
    task automatic t_reset();
        check(pll_ratio, 12'h001, "pll ratio reset");
        xfer(0, `CSU_CTRL_OFS, 0); check(rd, `CSU_CTRL_RESET, "ctrl reset");
        xfer(0, `CSU_BUSDIV_OFS, 0); check(rd, 32'h0000_0002, "busdiv reset");
        xfer(0, `CSU_CPUDIV_OFS, 0); check(rd, 32'h0000_0001, "cpudiv reset");
        xfer(0, `CSU_DDIV_OFS, 0); check(rd, 32'h0000_0002, "div reset");
        xfer(0, `CSU_FTW_OFS, 0); check(rd[4:0], 5'h1F, "ftw tc reset");
        xfer(1, 12'h100, 32'hFFFF_FFFF);
        xfer(0, 12'h100, 0); check(rd, 32'h0000_0000, "unmapped");
        $display("test reset done");
    endtask : t_reset
    task automatic t_config();
        for (int f = 0; f < 6; f++) begin
            for (int r = 0; r < 3; r++) begin
                xfer(1, `CSU_CTRL_OFS, (r << 12) | (f << 8) | ((f & 1) << 4));
                // the copies are launched one edge after the write lands; look one edge later
                repeat (2) @(posedge hclk);
                check(imo_freq_sel, f, "imo freq");
                check(imo_usb_mode, f & 1, "usb mode");
                check(pll_ref_sel, r, "pll ref");
                check(dbl_ref_sel, r, "doubler ref");
            end
        end
        xfer(1, `CSU_PLL_OFS, 32'h0000_0FBF);
        xfer(0, `CSU_PLL_OFS, 0); check(pll_ratio, 12'hFBF, "ratio out");
        check(rd[11:0], 12'hFBF, "ratio read");
        $display("test config done");
    endtask : t_config
    task automatic t_pll();
        xfer(1, `CSU_CTRL_OFS, 32'h0000_0008);
        n = 0;
        while (pll_lock !== 1'b1 && n < 14) begin @(posedge hclk); n++; end
        check(pll_lock, 1'b1, "lock in time");
        xfer(0, `CSU_STAT_OFS, 0); check(rd[13], 1'b1, "lock status");
        // the pll goes off before any low-power entry later on
        xfer(1, `CSU_CTRL_OFS, 0);
        repeat (3) @(posedge hclk);
        check(pll_lock, 1'b0, "lock drops");
        $display("test pll done");
    endtask : t_pll
    task automatic t_dividers();
        logic [11:0] a[6] = '{12'h040, 12'h044, 12'h060, 12'h05C, 12'h010, 12'h014};
        logic [31:0] v[6] = '{32'h4, 32'h2_0002, 32'h1_0006, 32'h7_0002, 32'h3, 32'h2};
        int k[6] = '{5, 6, 7, 8, 9, 10};
        int p[6] = '{4, 8, 12, 8, 3, 6};
        for (int i = 0; i < 6; i++) xfer(1, a[i], v[i]);
        repeat (40) @(posedge hclk);
        for (int i = 0; i < 6; i++) begin
            gap(k[i], 100);
            check(len, p[i], "divided period");
            if (i < 4) check(hi, p[i] / 2, "half duty");
        end
        $display("test dividers done");
    endtask : t_dividers
    task automatic t_lowspeed();
        gap(0, 3 * T100K); check(len, T100K, "100k period");
        gap(1, 9 * T100K); check(len, 3 * T100K, "33k period");
        gap(2, 3 * T1K); check(len, T1K, "1k period");
        c0 = slow_tick_counter;
        repeat (T1K) @(posedge hclk);
        check(slow_tick_counter, c0 + 13'h1, "slow step");
        // the counter is far from its wrap, so no slow interrupt may be seen
        check(stw_irq, 1'b0, "no slow irq before wrap");
        debug_halt <= 1'b1;
        @(posedge hclk);
        c0 = slow_tick_counter;
        repeat (T1K) @(posedge hclk);
        check(slow_tick_counter, c0, "debug hold");
        xfer(1, `CSU_CTRL_OFS, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        xfer(0, `CSU_STAT_OFS, 0); check(rd, 32'h0000_0000, "cleared");
        hibernate <= 1'b1;
        debug_halt <= 1'b0;
        repeat (T1K) @(posedge hclk);
        check(slow_tick_counter, 13'h0000, "hibernate hold");
        hibernate <= 1'b0;
        $display("test lowspeed done");
    endtask : t_lowspeed
    task automatic t_fast_rtc();
        xfer(1, `CSU_FTW_OFS, 32'h0000_0003);
        xfer(1, `CSU_CTRL_OFS, 32'h0000_0002);
        gap(3, 12 * T100K); check(len, 4 * T100K, "fast period");
        check(fast_tick <= 5'h03, 1'b1, "fast bound");
        xfer(1, `CSU_CTRL_OFS, 0);
        // a pulse launched at the edge where the disable lands still used the old enable
        @(posedge hclk);
        hi = 0;
        repeat (6 * T100K) begin @(posedge hclk); if (ftw_irq === 1'b1) hi++; end
        check(hi, 0, "fast irq off");
        watch_run <= 1'b1;
        gap(4, 200); check(len, 32, "rtc period");
        $display("test fast and rtc done");
    endtask : t_fast_rtc
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_config();
        t_pll();
        t_dividers();
        t_lowspeed();
        t_fast_rtc();
        print_verdict();
    end
endmodule : tb
